/* rcwl_flash_model.sv */
// ==========================================================
// Flash model holding the packed configuration words
module rcwl_flash_model
   import rcwl_pkg::*;
(
   // Clock
   input wire logic clk,
   // Read port
   input wire logic [15:0] flash_addr,
   input wire logic flash_rd,
   output logic [23:0] flash_rdata,
   output logic flash_valid,
   // Stored contents and pacing
   input wire logic [23:0] word_one,
   input wire logic [23:0] word_two,
   input wire logic slow
);
   timeunit 1ns;
   timeprecision 1ps;
   logic phase_q = 1'b0;
   logic [23:0] word;

   // Slow mode answers every other cycle only
   always @(posedge clk) phase_q <= ~phase_q;
   assign flash_valid = flash_rd && (!slow || phase_q);
   // Top words at fixed addresses; words three and four left erased-high
   assign word = (flash_addr == RCWL_ADDR_WORD_ONE) ? word_one :
      (flash_addr == RCWL_ADDR_WORD_TWO) ? word_two : RCWL_WORD_RESET;
   // Inverted data outside a valid beat, so stale data is never mistaken
   assign flash_rdata = flash_valid ? word : ~word;
endmodule

/* rcwl_loader.sv */
// Contract
// - Every device reset restarts the load of configuration words.
// - During reset copy flash words from the top addresses into registers.
// - Upper byte of each word is ignored and reads as ones.
// - Erased last page yields zero words, which enables code protection.
// - Bits 23-16 read one; word one bit 15 reserved, program zero.
// - Scan port enable cannot change while connected over the scan port; the code's reset still sets it to one while connected.
// - Word one bit 13 zero protects the whole program memory.
// - Word one bit 12 zero blocks all program memory writes.
// - Word one bit 11 zero enters debug mode after reset.
// - Bits 9-8 place emulator pins; code 00 reserved.
// - Bit 7 enables watchdog; bit 6 zero windowed, needs bit 7.
// - Bit 4 picks watchdog prescale 128 or 32.
// - Bits 3-0 set watchdog postscale to two to that power.
// - Word two bit 15 enables two-speed start-up.
// - Bits 14-12 select USB PLL input divider.
// - Bit 11 autostarts USB PLL, else software enable bit starts it.
// - Bits 10-8 select initial oscillator; 110 reserved.
// - Bits 7-6 set clock switching and fail-safe monitor.
// - Bit 5 selects clock-out or port pin in modes 11 and 00.
// - Bit 4 makes pin-select lock set-once after unlock.
// - Bit 2 selects default or alternate first I2C pins.
// - Bits 1-0 select primary oscillator mode.
module rcwl_loader
   import rcwl_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Flash read port
   output logic [15:0] flash_addr,
   output logic flash_rd,
   input wire logic [23:0] flash_rdata,
   input wire logic flash_valid,
   // Scan port session in progress
   input wire logic scan_port_connected,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Decoded configuration
   output logic load_done,
   output logic hold_in_reset,
   output logic scan_port_enable,
   output logic whole_code_protect,
   output logic flash_write_protect,
   output logic debug_mode,
   output logic [1:0] emulator_pin_select,
   output logic emulator_pins_invalid,
   output logic watchdog_on,
   output logic window_mode_off,
   output logic [7:0] watchdog_prescale,
   output logic [15:0] watchdog_postscale,
   output logic two_speed_startup,
   output logic [3:0] usb_pll_divisor,
   output logic usb_pll_run,
   output logic [2:0] initial_osc_select,
   output logic osc_select_invalid,
   output logic clock_switch_en,
   output logic fail_safe_en,
   output logic clock_output_pin,
   output logic pin_select_lock,
   output logic first_i2c_pin_select,
   output logic [1:0] primary_osc_mode
);

   // Every check below runs on the one clock, silenced during reset
   default clocking chk_cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   // ==========================================================
   // Load sequencer
   rcwl_state_t state_q, state_d;
   logic [1:0] idx_q, idx_d;
   logic [23:0] words_q [RCWL_NUM_WORDS];
   logic scan_en_q;
   logic lock_q, lock_once_q, pll_sw_q;
   logic [15:0] w1, w2;
   rcwl_word_one_t c1;
   rcwl_word_two_t c2;

   // Restart from state idle on any reset, volatile words refilled
   always_comb begin
      state_d = state_q;
      idx_d = idx_q;
      case (state_q)
         RCWL_IDLE: state_d = RCWL_FETCH;
         RCWL_FETCH: begin
            if (flash_valid) begin
               idx_d = idx_q + 2'd1;
               if (idx_q == 2'd3) begin
                  state_d = RCWL_DONE;
               end
            end
         end
         RCWL_DONE: state_d = RCWL_DONE;
         default: state_d = RCWL_IDLE;
      endcase
   end

   assign flash_rd = (state_q == RCWL_FETCH);
   // Descend from the top word by two per step
   assign flash_addr = RCWL_ADDR_WORD_ONE - 16'({idx_q, 1'b0});

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= RCWL_IDLE;
         idx_q <= 2'd0;
      end else begin
         state_q <= state_d;
         idx_q <= idx_d;
      end
   end

   // Word capture; upper byte forced to ones since nothing lives there
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < RCWL_NUM_WORDS; i++) begin
            words_q[i] <= RCWL_WORD_RESET;
         end
      end else if (flash_rd && flash_valid) begin
         words_q[idx_q] <= {RCWL_UPPER_ONES, flash_rdata[15:0]};
      end
   end

   // Unimplemented low bits read as ones
   assign w1 = words_q[0][15:0] | RCWL_WORD1_FIXED_ONES;
   assign w2 = words_q[1][15:0] | RCWL_WORD2_FIXED_ONES;
   assign c1 = {w1[14:11], w1[9:6], w1[4:0]};
   assign c2 = {w2[15:4], w2[2:0]};

   // ==========================================================
   // Scan port enable: reset loads one; a reload during a scan session keeps that one
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         scan_en_q <= 1'b1;
      end else if (flash_rd && flash_valid && idx_q == 2'd0 && !scan_port_connected) begin
         scan_en_q <= flash_rdata[14];
      end
   end

   // ==========================================================
   // Decoded outputs; erased word gives zeros and protection on
   assign load_done = (state_q == RCWL_DONE);
   assign hold_in_reset = !load_done;
   assign scan_port_enable = scan_en_q;
   assign whole_code_protect = !c1.whole_code_protect;
   assign flash_write_protect = !c1.flash_write_protect;
   assign debug_mode = !c1.debug_mode;
   assign emulator_pin_select = c1.emulator_pin_select;
   assign emulator_pins_invalid = (c1.emulator_pin_select == 2'b00);
   assign watchdog_on = c1.watchdog_on;
   // Windowed mode only meaningful with the watchdog on
   assign window_mode_off = c1.window_mode_off | !c1.watchdog_on;
   assign watchdog_prescale = c1.watchdog_prescale_sel ? RCWL_WDT_PRE_LONG
                                                       : RCWL_WDT_PRE_SHORT;
   assign watchdog_postscale = 16'h0001 << c1.watchdog_postscale_sel;
   assign two_speed_startup = c2.two_speed_startup;

   // USB PLL input divider table
   always_comb begin
      case (c2.usb_pll_prescale)
         3'b111: usb_pll_divisor = 4'd12;
         3'b110: usb_pll_divisor = 4'd8;
         3'b101: usb_pll_divisor = 4'd6;
         3'b100: usb_pll_divisor = 4'd5;
         3'b011: usb_pll_divisor = 4'd4;
         3'b010: usb_pll_divisor = 4'd3;
         3'b001: usb_pll_divisor = 4'd2;
         default: usb_pll_divisor = 4'd1;
      endcase
   end

   assign usb_pll_run = load_done & (c2.usb_pll_autostart | pll_sw_q);
   assign initial_osc_select = c2.initial_osc_select;
   assign osc_select_invalid = (c2.initial_osc_select == 3'b110);
   assign clock_switch_en = !c2.switch_and_monitor_cfg[1];
   assign fail_safe_en = (c2.switch_and_monitor_cfg == 2'b00);
   // Clock-out only with oscillator mode 11 or 00
   assign clock_output_pin = c2.osc_out_pin_function
      & (c2.primary_osc_mode[1] == c2.primary_osc_mode[0]);
   assign pin_select_lock = lock_q;
   assign first_i2c_pin_select = c2.first_i2c_pin_select;
   assign primary_osc_mode = c2.primary_osc_mode;

   // ==========================================================
   // APB slave, zero wait states
   logic acc, wr;
   logic [31:0] rd_d;
   assign acc = psel & penable;
   assign wr = acc & pwrite;
   assign pready = 1'b1;
   assign pslverr = 1'b0;

   // Read mux; config words are read only
   always_comb begin
      case (paddr)
         RCWL_OFS_WORD_ONE: rd_d = {8'h00, words_q[0][23:16], w1};
         RCWL_OFS_WORD_TWO: rd_d = {8'h00, words_q[1][23:16], w2};
         RCWL_OFS_WORD_THREE: rd_d = {8'h00, words_q[2]};
         RCWL_OFS_WORD_FOUR: rd_d = {8'h00, words_q[3]};
         RCWL_OFS_STATUS: rd_d = {31'h0, load_done};
         RCWL_OFS_PIN_LOCK: rd_d = 32'(lock_q) << RCWL_LOCK_BIT;
         RCWL_OFS_CLOCK_DIVIDER_REG: rd_d = 32'(pll_sw_q) << RCWL_CLOCK_DIVIDER_REG_PLL_EN_BIT;
         default: rd_d = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= rd_d;
      end
   end

   // Pin lock and software PLL enable; one-shot lock refuses clearing
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         lock_q <= 1'b0;
         lock_once_q <= 1'b0;
         pll_sw_q <= RCWL_CLOCK_DIVIDER_REG_RESET[RCWL_CLOCK_DIVIDER_REG_PLL_EN_BIT];
      end else begin
         if (wr && paddr == RCWL_OFS_PIN_LOCK && !lock_once_q) begin
            lock_q <= pwdata[RCWL_LOCK_BIT];
            lock_once_q <= pwdata[RCWL_LOCK_BIT] & c2.pin_lock_one_shot;
         end
         if (wr && paddr == RCWL_OFS_CLOCK_DIVIDER_REG) begin
            pll_sw_q <= pwdata[RCWL_CLOCK_DIVIDER_REG_PLL_EN_BIT];
         end
      end
   end

   // ==========================================================
   // Checks: load sequence and reload
   sequence s_mid_beat;
      flash_rd && flash_valid && idx_q != 2'd3;
   endsequence
   sequence s_last_beat;
      flash_rd && flash_valid && idx_q == 2'd3;
   endsequence
   // Two done cycles in a row, so $stable compares loaded values only
   sequence s_settled;
      load_done ##1 load_done;
   endsequence

   a_load_addr_top: assert property (
      (state_q == RCWL_IDLE) |=> (flash_addr == RCWL_ADDR_WORD_ONE))
      else $error("load does not start at top word");

   a_addr_step: assert property (
      s_mid_beat |=> (flash_addr == $past(flash_addr) - RCWL_ADDR_STEP))
      else $error("fetch address did not step down");

   a_done_after_four: assert property (
      s_last_beat |=> load_done)
      else $error("load not done after fourth word");

   a_reload_restart: assert property ($rose(reset_n) |-> !load_done)
      else $error("load done right after reset");
   a_reset_holds: assert property (!load_done |-> hold_in_reset)
      else $error("core released before load done");
   a_no_fetch_done: assert property (load_done |-> !flash_rd)
      else $error("flash read after load done");

   a_words_stable: assert property (
      s_settled |-> $stable(w1) && $stable(w2))
      else $error("config changed after load");

   // A bus write to word one must never reach loaded word one
   a_word_ro: assert property (
      (load_done && wr && paddr == RCWL_OFS_WORD_ONE) |=> $stable(words_q[0]))
      else $error("bus write changed a config word");

   // ==========================================================
   // Checks: stored word layout
   a_upper_ones: assert property (
      load_done |-> words_q[0][23:16] == RCWL_UPPER_ONES)
      else $error("upper byte not ones");

   a_upper_two: assert property (words_q[1][23:16] == RCWL_UPPER_ONES)
      else $error("word two upper byte not ones");
   a_upper_three: assert property (words_q[2][23:16] == RCWL_UPPER_ONES)
      else $error("word three upper byte not ones");
   a_upper_four: assert property (words_q[3][23:16] == RCWL_UPPER_ONES)
      else $error("word four upper byte not ones");
   a_fixed_one: assert property (w1[10] && w1[5])
      else $error("unimplemented word one bit reads zero");
   a_fixed_two: assert property (w2[3])
      else $error("unimplemented word two bit reads zero");

   // ==========================================================
   // Checks: word one decode
   a_scan_hold: assert property (scan_port_connected |=> $stable(scan_en_q))
      else $error("scan enable changed while connected");

   a_scan_load: assert property (
      (flash_rd && flash_valid && idx_q == 2'd0 && !scan_port_connected)
      |=> (scan_en_q == $past(flash_rdata[14])))
      else $error("scan enable not loaded");

   a_code_prot: assert property (whole_code_protect == !w1[13])
      else $error("code protect mismatch");
   a_write_prot: assert property (flash_write_protect == !w1[12])
      else $error("write protect mismatch");

   // Erased words leave only the forced ones, so both protections apply
   a_erased_prot: assert property (
      (w1 == RCWL_WORD1_FIXED_ONES) |-> (whole_code_protect && flash_write_protect))
      else $error("erased word leaves memory unprotected");

   a_debug_entry: assert property (debug_mode == !w1[11])
      else $error("debug entry mismatch");
   a_emu_pins: assert property (emulator_pin_select == w1[9:8])
      else $error("emulator pin select mismatch");

   a_emu_reserved: assert property (
      emulator_pins_invalid == (w1[9:8] == 2'b00))
      else $error("reserved emulator code not flagged");

   a_wdt_enable: assert property (watchdog_on == w1[7])
      else $error("watchdog enable mismatch");

   // Windowed operation is never reported without the watchdog
   a_window_needs_wdt: assert property (!window_mode_off |-> watchdog_on)
      else $error("window mode without watchdog");

   a_prescale_ratio: assert property (
      watchdog_prescale == (w1[4] ? RCWL_WDT_PRE_LONG : RCWL_WDT_PRE_SHORT))
      else $error("watchdog prescale mismatch");

   a_postscale: assert property (
      watchdog_postscale[w1[3:0]] && $onehot(watchdog_postscale))
      else $error("postscale decode wrong");

   // ==========================================================
   // Checks: word two decode and software registers
   a_two_speed: assert property (two_speed_startup == w2[15])
      else $error("two-speed start-up mismatch");
   a_pll_direct: assert property ((w2[14:12] == 3'b000) |-> usb_pll_divisor == 4'h1)
      else $error("undivided PLL input mismatch");
   a_pll_max_div: assert property ((w2[14:12] == 3'b111) |-> usb_pll_divisor == 4'hc)
      else $error("divide by twelve mismatch");
   a_pll_auto: assert property ((load_done && w2[11]) |-> usb_pll_run)
      else $error("USB PLL did not autostart");
   a_pll_gated: assert property (!load_done |-> !usb_pll_run)
      else $error("USB PLL runs before load done");

   a_pll_soft_wr: assert property (
      (wr && paddr == RCWL_OFS_CLOCK_DIVIDER_REG)
      |=> (pll_sw_q == $past(pwdata[RCWL_CLOCK_DIVIDER_REG_PLL_EN_BIT])))
      else $error("software PLL enable not written");

   a_osc_select: assert property (initial_osc_select == w2[10:8])
      else $error("initial oscillator mismatch");
   a_osc_reserved: assert property (osc_select_invalid == (w2[10:8] == 3'b110))
      else $error("reserved oscillator code not flagged");
   a_switch_off: assert property (w2[7] |-> (!clock_switch_en && !fail_safe_en))
      else $error("switching enabled with bit 7 set");
   a_monitor_switch: assert property (fail_safe_en |-> clock_switch_en)
      else $error("monitor on without clock switching");

   // Clock-out pin only ever driven in oscillator modes 11 and 00
   a_clkout: assert property (
      (w2[1:0] == 2'b10 || w2[1:0] == 2'b01) |-> !clock_output_pin)
      else $error("clock-out in crystal mode");

   a_clkout_on: assert property (
      (w2[5] && w2[1:0] == 2'b00) |-> clock_output_pin)
      else $error("clock-out missing in external clock mode");

   a_lock_once: assert property (lock_once_q |=> lock_q)
      else $error("one-shot lock cleared");
   a_lock_write: assert property (
      (wr && paddr == RCWL_OFS_PIN_LOCK && !lock_once_q)
      |=> (lock_q == $past(pwdata[RCWL_LOCK_BIT])))
      else $error("pin lock write not taken");

   a_i2c_pins: assert property (first_i2c_pin_select == w2[2])
      else $error("first I2C pin select mismatch");
   a_posc_mode: assert property (primary_osc_mode == w2[1:0])
      else $error("primary oscillator mode mismatch");
endmodule

/* rcwl_pkg.sv */
package rcwl_pkg;
   // ==========================================================
   // Flash word addresses of the packed configuration words
   localparam logic [15:0] RCWL_ADDR_WORD_ONE = 16'habfe;
   localparam logic [15:0] RCWL_ADDR_WORD_TWO = 16'habfc;
   localparam logic [15:0] RCWL_ADDR_WORD_THREE = 16'habfa;
   localparam logic [15:0] RCWL_ADDR_WORD_FOUR = 16'habf8;
   localparam logic [15:0] RCWL_ADDR_STEP = 16'h0002;
   localparam int RCWL_NUM_WORDS = 4;

   // ==========================================================
   // APB register byte offsets
   localparam logic [7:0] RCWL_OFS_WORD_ONE = 8'h00;
   localparam logic [7:0] RCWL_OFS_WORD_TWO = 8'h04;
   localparam logic [7:0] RCWL_OFS_WORD_THREE = 8'h08;
   localparam logic [7:0] RCWL_OFS_WORD_FOUR = 8'h0c;
   localparam logic [7:0] RCWL_OFS_STATUS = 8'h10;
   localparam logic [7:0] RCWL_OFS_PIN_LOCK = 8'h14;
   localparam logic [7:0] RCWL_OFS_CLOCK_DIVIDER_REG = 8'h18;

   // ==========================================================
   // Field positions and reset values
   localparam logic [7:0] RCWL_UPPER_ONES = 8'hff;
   localparam logic [23:0] RCWL_WORD_RESET = 24'hffffff;
   localparam logic [15:0] RCWL_WORD1_FIXED_ONES = 16'h0420;
   localparam logic [15:0] RCWL_WORD2_FIXED_ONES = 16'h0008;
   localparam int RCWL_CLOCK_DIVIDER_REG_PLL_EN_BIT = 5;
   localparam int RCWL_LOCK_BIT = 6;
   localparam logic [31:0] RCWL_CLOCK_DIVIDER_REG_RESET = 32'h0000_0000;

   // Watchdog prescale ratios
   localparam logic [7:0] RCWL_WDT_PRE_LONG = 8'h80;
   localparam logic [7:0] RCWL_WDT_PRE_SHORT = 8'h20;

   typedef struct packed {
      logic scan_port_enable;
      logic whole_code_protect;
      logic flash_write_protect;
      logic debug_mode;
      logic [1:0] emulator_pin_select;
      logic watchdog_on;
      logic window_mode_off;
      logic watchdog_prescale_sel;
      logic [3:0] watchdog_postscale_sel;
   } rcwl_word_one_t;

   typedef struct packed {
      logic two_speed_startup;
      logic [2:0] usb_pll_prescale;
      logic usb_pll_autostart;
      logic [2:0] initial_osc_select;
      logic [1:0] switch_and_monitor_cfg;
      logic osc_out_pin_function;
      logic pin_lock_one_shot;
      logic first_i2c_pin_select;
      logic [1:0] primary_osc_mode;
   } rcwl_word_two_t;

   typedef enum logic [1:0] {
      RCWL_IDLE,
      RCWL_FETCH,
      RCWL_DONE
   } rcwl_state_t;
endpackage

/* tb_reset_config_word_loader.sv */
`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin \
   mismatches++; $display("[ERR] %s expected %0h seen %0h", nm, exp, got); end end
// ==========================================================
// Bench for the configuration loader
module tb_reset_config_word_loader;
   timeunit 1ns;
   timeprecision 1ps;
   import rcwl_pkg::*;
   int mismatches = 0;
   int samples_checked = 0;
   logic clk = 1'b0, reset_n = 1'b0, slow = 1'b0, scan_port_connected = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic [23:0] word_one = 24'hffffff, word_two = 24'hffffff, flash_rdata;
   logic [15:0] flash_addr, watchdog_postscale;
   logic [15:0] addr_q[$];
   logic flash_rd, flash_valid, pready, pslverr, load_done, hold_in_reset, scan_port_enable;
   logic whole_code_protect, flash_write_protect, debug_mode, emulator_pins_invalid;
   logic watchdog_on, window_mode_off, two_speed_startup, usb_pll_run, osc_select_invalid;
   logic clock_switch_en, fail_safe_en, clock_output_pin, pin_select_lock, first_i2c_pin_select;
   logic [1:0] emulator_pin_select, primary_osc_mode;
   logic [7:0] watchdog_prescale;
   logic [3:0] usb_pll_divisor;
   logic [2:0] initial_osc_select;

   rcwl_loader rcwl_loader_inst (.clk, .reset_n, .flash_addr, .flash_rd, .flash_rdata,
      .flash_valid, .scan_port_connected, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .load_done, .hold_in_reset, .scan_port_enable,
      .whole_code_protect, .flash_write_protect, .debug_mode, .emulator_pin_select,
      .emulator_pins_invalid, .watchdog_on, .window_mode_off, .watchdog_prescale,
      .watchdog_postscale, .two_speed_startup, .usb_pll_divisor, .usb_pll_run,
      .initial_osc_select, .osc_select_invalid, .clock_switch_en, .fail_safe_en,
      .clock_output_pin, .pin_select_lock, .first_i2c_pin_select, .primary_osc_mode);
   rcwl_flash_model rcwl_flash_model_inst (.clk, .flash_addr, .flash_rd, .flash_rdata,
      .flash_valid, .word_one, .word_two, .slow);

   // ==========================================================
   // Clock, fetch monitor and hang guard
   initial begin
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) if (flash_rd && flash_valid) addr_q.push_back(flash_addr);
   initial begin
      #500000;
      mismatches++;
      summarize();
   end

   // ==========================================================
   // Tasks
   task automatic summarize();
      $display("Comparisons %0d, mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   // One APB transfer; request held until pready is seen high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
         output logic [31:0] rd);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) mismatches++;
      #1; // Let registers written at this edge settle before callers look
   endtask

   task automatic load(input logic [23:0] w1, input logic [23:0] w2, input logic s);
      int n;
      n = 0;
      @(posedge clk);
      word_one <= w1;
      word_two <= w2;
      slow <= s;
      reset_n <= 1'b0;
      repeat (8) @(posedge clk);
      `CHK("hold_in_reset", 1'b1, hold_in_reset)
      addr_q.delete();
      reset_n <= 1'b1;
      while (load_done !== 1'b1 && n < 100) begin
         @(posedge clk);
         n++;
      end
      `CHK("load_done", 1'b1, load_done)
      `CHK("released", 1'b0, hold_in_reset)
      `CHK("fetch count", 4, addr_q.size())
      foreach (addr_q[k]) `CHK("flash_addr", 16'(RCWL_ADDR_WORD_ONE - 2 * k), addr_q[k])
   endtask

   task automatic check_decode(input logic [15:0] w1, input logic [15:0] w2, input logic sc);
      logic [31:0] rd;
      logic [3:0] divs[8];
      divs = '{4'd1, 4'd2, 4'd3, 4'd4, 4'd5, 4'd6, 4'd8, 4'd12};
      `CHK("scan", sc, scan_port_enable)
      `CHK("code protect", ~w1[13], whole_code_protect)
      `CHK("write protect", ~w1[12], flash_write_protect)
      `CHK("debug", ~w1[11], debug_mode)
      `CHK("emu pins", w1[9:8], emulator_pin_select)
      `CHK("emu bad", w1[9:8] == 2'b00, emulator_pins_invalid)
      `CHK("wdt on", w1[7], watchdog_on)
      `CHK("window off", w1[6] | ~w1[7], window_mode_off)
      `CHK("prescale", w1[4] ? RCWL_WDT_PRE_LONG : RCWL_WDT_PRE_SHORT, watchdog_prescale)
      `CHK("postscale", 16'h0001 << w1[3:0], watchdog_postscale)
      `CHK("two speed", w2[15], two_speed_startup)
      `CHK("pll div", divs[w2[14:12]], usb_pll_divisor)
      `CHK("pll run", w2[11], usb_pll_run)
      `CHK("osc sel", w2[10:8], initial_osc_select)
      `CHK("osc bad", w2[10:8] == 3'b110, osc_select_invalid)
      `CHK("switch", ~w2[7], clock_switch_en)
      `CHK("fail safe", w2[7:6] == 2'b00, fail_safe_en)
      `CHK("clk out", w2[5] & (w2[1:0] == 2'b11 || w2[1:0] == 2'b00), clock_output_pin)
      `CHK("i2c pins", w2[2], first_i2c_pin_select)
      `CHK("posc mode", w2[1:0], primary_osc_mode)
      apb(1'b0, RCWL_OFS_WORD_ONE, 32'h0, rd);
      `CHK("word one", {8'h00, RCWL_UPPER_ONES, w1 | RCWL_WORD1_FIXED_ONES}, rd)
      apb(1'b0, RCWL_OFS_WORD_TWO, 32'h0, rd);
      `CHK("word two", {8'h00, RCWL_UPPER_ONES, w2 | RCWL_WORD2_FIXED_ONES}, rd)
   endtask

   // Flash changes and a refused write must not disturb loaded values
   task automatic test_hold();
      logic [31:0] rd;
      load(24'hff3c96, 24'hff5a17, 1'b0);
      word_one <= 24'h000000;
      word_two <= 24'h000000;
      apb(1'b1, RCWL_OFS_WORD_ONE, 32'h0, rd);
      repeat (20) @(posedge clk);
      check_decode(16'h3c96, 16'h5a17, 1'b0);
      apb(1'b0, RCWL_OFS_STATUS, 32'h0, rd);
      `CHK("status", 32'h1, rd)
      apb(1'b0, 8'h1c, 32'h0, rd);
      `CHK("unmapped", 32'h0, rd)
      `CHK("no error", 1'b0, pslverr)
      $display("test hold done");
   endtask

   task automatic test_lock(input logic one_shot);
      logic [31:0] rd;
      load(24'hffffff, one_shot ? 24'hff07ff : 24'hff07ef, 1'b1);
      `CHK("pll idle", 1'b0, usb_pll_run)
      apb(1'b1, RCWL_OFS_CLOCK_DIVIDER_REG, 32'h20, rd);
      `CHK("pll soft", 1'b1, usb_pll_run)
      apb(1'b1, RCWL_OFS_PIN_LOCK, 32'h40, rd);
      `CHK("lock set", 1'b1, pin_select_lock)
      apb(1'b1, RCWL_OFS_PIN_LOCK, 32'h0, rd);
      `CHK("lock clear", one_shot, pin_select_lock)
      $display("test lock %0d done", one_shot);
   endtask

   // Scan enable frozen while a scan session is connected
   task automatic test_scan();
      @(posedge clk);
      scan_port_connected <= 1'b1;
      load(24'hffbfff, 24'hffffff, 1'b0);
      `CHK("scan frozen", 1'b1, scan_port_enable)
      scan_port_connected <= 1'b0;
      load(24'hffbfff, 24'hffffff, 1'b0);
      `CHK("scan loaded", 1'b0, scan_port_enable)
      $display("test scan done");
   endtask

   // ==========================================================
   // Main sequence; index 16 is an erased last page
   initial begin
      logic [15:0] w1;
      logic [15:0] w2;
      for (int i = 0; i <= 16; i++) begin
         w1 = (i == 16) ? 16'h0 : 16'h5a5a ^ (16'(i) * 16'h1111);
         w2 = (i == 16) ? 16'h0 : 16'hc3c3 ^ (16'(i) * 16'h1111);
         load({(i == 16) ? 8'h00 : 8'hff, w1}, {(i == 16) ? 8'h00 : 8'hff, w2}, i[0]);
         check_decode(w1, w2, w1[14]);
         $display("test decode %0d done", i);
      end
      test_hold();
      test_lock(1'b0);
      test_lock(1'b1);
      test_scan();
      summarize();
   end
endmodule
